// ### hw/frc_top.sv
// serial flash read-configuration logic: nonvolatile and volatile config
// registers, register commands, fast read with dummy cycles and wrap.
// assumes spi mode 0 pins from the host, array data from a same-clock
// source with valid/ready, and sclk well below a quarter of CLOCK_IN.
//
// Function
// - nonvolatile register starts all ones and fixes power-on config
// - dedicated commands read and write the nonvolatile register
// - dummy codes all zeros and all ones both give the default count
// - reset image nv bits 2,3 both clear give quad; written nv bits never do
// - volatile bits 7:4 give dummy cycles after fast-read address
// - volatile bit 3 low enables execute in place; forced on variants
// - volatile bits 1:0 select wrap 16, 32, 64 bytes or continuous
// - wrap starts at sent address, runs to block end, back to start
// - wrap code 11 streams sequential addresses with no wrapping
// - volatile writes act at once and read back by its command
// - nv bits 15:12 are stored only; the dummy count comes from volatile bits 7:4
// - reset image nv bit 3 low enables quad, bit 2 low with bit 3 high dual, default ones
`timescale 1ns/1ps
`include "frc_params.svh"

module frc_top
   import frc_pkg::*;
#(
   parameter logic XIP_FORCED = 1'b0
) (
   input  wire logic        CLOCK_IN,
   input  wire logic        ARST_N_IN,
   input  wire logic        SCLK_IN,
   input  wire logic        CS_N_IN,
   input  wire logic        MOSI_IN,
   input  wire logic [7:0]  ARRAY_DATA_IN,
   input  wire logic        ARRAY_VALID_IN,
   output logic             ARRAY_READY_OUT,
   output logic [23:0]      ARRAY_ADDR_OUT,
   output logic             MISO_OUT,
   output logic             MISO_OE_OUT,
   output logic             QUAD_MODE_OUT,
   output logic             DUAL_MODE_OUT,
   output logic             EXECUTE_IN_PLACE_MODE_OUT,
   output logic [7:0]       VOL_CONFIG_OUT
);

   function automatic logic [3:0] dummy_decode(input logic [3:0] code);
      if (code == 4'h0 || code == 4'hf)
         return `FRC_DUMMY_DEFAULT;
      return code;
   endfunction : dummy_decode

   function automatic logic [23:0] wrap_next(input logic [23:0] a,
                                             input logic [1:0]  w);
      logic [23:0] r;
      r = a + 24'h1;
      case (w)
         `FRC_WRAP_16: r = {a[23:4], a[3:0] + 4'h1};
         `FRC_WRAP_32: r = {a[23:5], a[4:0] + 5'h1};
         `FRC_WRAP_64: r = {a[23:6], a[5:0] + 6'h1};
         default:      r = a + 24'h1;
      endcase
      return r;
   endfunction : wrap_next

   frc_regs_t st;
   frc_regs_t next_st;
   logic      rise_edge;
   logic      fall_edge;
   logic      cs_active;
   logic      mosi_bit;

   // edges come from the second and third flops only
   assign rise_edge = st.sclk_sync[1] & ~st.sclk_sync[2];
   assign fall_edge = ~st.sclk_sync[1] & st.sclk_sync[2];
   assign cs_active = ~st.cs_sync[1];
   assign mosi_bit  = st.mosi_sync[1];

   always_comb begin
      logic       push;
      logic       pop;
      logic       flush;
      logic [7:0] byte_out;
      logic [7:0] shifted;
      push     = st.ready & ARRAY_VALID_IN;
      pop      = 1'b0;
      flush    = 1'b0;
      byte_out = 8'h00;
      shifted  = {st.in_sr[6:0], mosi_bit};
      next_st  = st;
      next_st.sclk_sync = {st.sclk_sync[1:0], SCLK_IN};
      next_st.cs_sync   = {st.cs_sync[0], CS_N_IN};
      next_st.mosi_sync = {st.mosi_sync[0], MOSI_IN};
      if (!cs_active) begin
         next_st.state   = ST_CMD;
         next_st.bit_cnt = 5'h0;
         next_st.miso_oe = 1'b0;
         next_st.fill_on = 1'b0;
      end else begin
         case (st.state)
            ST_CMD: if (rise_edge) begin
               next_st.in_sr   = {st.in_sr[22:0], mosi_bit};
               next_st.bit_cnt = st.bit_cnt + 5'h1;
               if (st.bit_cnt == 5'h7) begin
                  next_st.bit_cnt = 5'h0;
                  next_st.state   = ST_IGNORE;
                  case (shifted)
                     `FRC_OP_RD_NV: begin
                        next_st.out_sr = st.nv;
                        next_st.state  = ST_REG;
                     end
                     `FRC_OP_RD_VOL: begin
                        next_st.out_sr = {st.vol, st.vol};
                        next_st.state  = ST_REG;
                     end
                     `FRC_OP_WR_NV: begin
                        next_st.is_nv = 1'b1;
                        next_st.state = ST_WDATA;
                     end
                     `FRC_OP_WR_VOL: begin
                        next_st.is_nv = 1'b0;
                        next_st.state = ST_WDATA;
                     end
                     `FRC_OP_FAST_READ: next_st.state = ST_ADDR;
                     default: next_st.state = ST_IGNORE;
                  endcase
               end
            end
            ST_WDATA: if (rise_edge) begin
               next_st.in_sr   = {st.in_sr[22:0], mosi_bit};
               next_st.bit_cnt = st.bit_cnt + 5'h1;
               if (st.is_nv && st.bit_cnt == 5'hf) begin
                  next_st.nv    = {st.in_sr[14:0], mosi_bit};
                  next_st.state = ST_IGNORE;
               end else if (!st.is_nv && st.bit_cnt == 5'h7) begin
                  next_st.vol   = shifted;
                  next_st.vol[`FRC_RSVD_BIT] = 1'b0;
                  next_st.state = ST_IGNORE;
               end
            end
            ST_ADDR: if (rise_edge) begin
               next_st.in_sr   = {st.in_sr[22:0], mosi_bit};
               next_st.bit_cnt = st.bit_cnt + 5'h1;
               if (st.bit_cnt == 5'h17) begin
                  // fetch starts during the dummy phase
                  next_st.fill_addr = {st.in_sr[22:0], mosi_bit};
                  next_st.fill_on   = 1'b1;
                  flush             = 1'b1;
                  next_st.dcnt  = dummy_decode(
                     st.vol[`FRC_DUMMY_HI:`FRC_DUMMY_LO]);
                  next_st.state = ST_DUMMY;
               end
            end
            ST_DUMMY: if (rise_edge) begin
               next_st.dcnt = st.dcnt - 4'h1;
               if (st.dcnt == 4'h1) begin
                  next_st.state   = ST_ARRAY;
                  next_st.out_bit = 3'h0;
               end
            end
            ST_ARRAY: if (fall_edge) begin
               next_st.miso_oe = 1'b1;
               next_st.out_bit = st.out_bit + 3'h1;
               if (st.out_bit == 3'h0) begin
                  // an underrun sends zeros rather than stall the host
                  if (st.buf_cnt != 2'h0) begin
                     byte_out = st.buf_mem[st.rd_ptr];
                     pop      = 1'b1;
                  end
                  next_st.miso   = byte_out[7];
                  next_st.out_sr = {byte_out[6:0], 9'h000};
               end else begin
                  next_st.miso   = st.out_sr[15];
                  next_st.out_sr = {st.out_sr[14:0], 1'b0};
               end
            end
            ST_REG: if (fall_edge) begin
               next_st.miso_oe = 1'b1;
               next_st.miso    = st.out_sr[15];
               next_st.out_sr  = {st.out_sr[14:0], st.out_sr[15]};
            end
            ST_IGNORE: next_st.miso_oe = 1'b0;
            default: next_st.state = ST_IGNORE;
         endcase
      end
      // two-entry buffer; ready drops at full so the array source stalls
      if (flush) begin
         next_st.buf_cnt = 2'h0;
         next_st.wr_ptr  = 1'b0;
         next_st.rd_ptr  = 1'b0;
      end else begin
         if (push) begin
            next_st.buf_mem[st.wr_ptr] = ARRAY_DATA_IN;
            next_st.wr_ptr    = ~st.wr_ptr;
            next_st.fill_addr = wrap_next(st.fill_addr,
                                          st.vol[1:0]);
         end
         if (pop)
            next_st.rd_ptr = ~st.rd_ptr;
         next_st.buf_cnt = st.buf_cnt + {1'b0, push} - {1'b0, pop};
      end
      next_st.ready = next_st.fill_on & (next_st.buf_cnt != 2'h2);
      next_st.execute_in_place_mode   = XIP_FORCED | ~next_st.vol[`FRC_XIP_BIT];
   end

   // literals cannot be bit-selected, so the images get names first
   localparam logic [15:0] NV_INIT  = `FRC_NV_RESET;
   localparam logic [7:0]  VOL_INIT = `FRC_VOL_RESET;

   localparam frc_regs_t RESET_ST = '{
      state: ST_CMD, sclk_sync: 3'h0, cs_sync: 2'h3, mosi_sync: 2'h0,
      bit_cnt: 5'h0, in_sr: 24'h0, is_nv: 1'b0, out_sr: 16'h0,
      out_bit: 3'h0, dcnt: 4'h0, fill_addr: 24'h0, fill_on: 1'b0,
      buf_mem: 16'h0, wr_ptr: 1'b0, rd_ptr: 1'b0, buf_cnt: 2'h0,
      ready: 1'b0, miso: 1'b0, miso_oe: 1'b0,
      nv: NV_INIT,
      vol: VOL_INIT,
      // protocol is fixed from the nv image at power-on only
      quad: ~NV_INIT[`FRC_NV_QUAD_BIT],
      dual: ~NV_INIT[`FRC_NV_DUAL_BIT]
            & NV_INIT[`FRC_NV_QUAD_BIT],
      execute_in_place_mode: XIP_FORCED | ~VOL_INIT[`FRC_XIP_BIT]};

   always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN)
         st <= RESET_ST;
      else
         st <= next_st;
   end

   assign ARRAY_READY_OUT           = st.ready;
   assign ARRAY_ADDR_OUT            = st.fill_addr;
   assign MISO_OUT                  = st.miso;
   assign MISO_OE_OUT               = st.miso_oe;
   assign QUAD_MODE_OUT             = st.quad;
   assign DUAL_MODE_OUT             = st.dual;
   assign EXECUTE_IN_PLACE_MODE_OUT = st.execute_in_place_mode;
   assign VOL_CONFIG_OUT            = st.vol;

   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (!ARST_N_IN);

   sequence s_vol_last;
      cs_active && st.state == ST_WDATA && !st.is_nv && rise_edge
         && st.bit_cnt == 5'h7;
   endsequence
   sequence s_nv_last;
      cs_active && st.state == ST_WDATA && st.is_nv && rise_edge
         && st.bit_cnt == 5'hf;
   endsequence
   sequence s_addr_done;
      cs_active && st.state == ST_ADDR && rise_edge && st.bit_cnt == 5'h17;
   endsequence

   vol_reserved_zero_a: assert property (st.vol[2] == 1'b0)
      else $error("reserved volatile bit set");
   vol_write_now_a: assert property (s_vol_last |=>
      st.vol[1:0] == $past({st.in_sr[0], mosi_bit})
      && st.state == ST_IGNORE)
      else $error("volatile write not applied");
   nv_write_a: assert property (s_nv_last |=>
      st.nv == $past({st.in_sr[14:0], mosi_bit}))
      else $error("nonvolatile write not stored");
   dummy_load_a: assert property (s_addr_done |=>
      st.state == ST_DUMMY
      && st.dcnt == ((st.vol[7:4] == 4'h0 || st.vol[7:4] == 4'hf)
                     ? `FRC_DUMMY_DEFAULT : st.vol[7:4]))
      else $error("dummy count loaded wrong");
   wrap_block_a: assert property (
      st.ready && ARRAY_VALID_IN && st.vol[1:0] == 2'h0 |=>
      st.fill_addr[23:4] == $past(st.fill_addr[23:4])
      && st.fill_addr[3:0] == $past(st.fill_addr[3:0]) + 4'h1)
      else $error("16-byte wrap address wrong");
   sequential_a: assert property (
      st.ready && ARRAY_VALID_IN && st.vol[1:0] == 2'h3 |=>
      st.fill_addr == $past(st.fill_addr) + 24'h1)
      else $error("sequential address wrong");
   protocol_fixed_a: assert property (
      $stable(QUAD_MODE_OUT) && $stable(DUAL_MODE_OUT))
      else $error("protocol changed without power-on");
   xip_follow_a: assert property (s_vol_last |=>
      EXECUTE_IN_PLACE_MODE_OUT == (XIP_FORCED | ~st.vol[3]))
      else $error("execute in place flag stale");
   buffer_full_a: assert property (
      st.buf_cnt == 2'h2 |-> !st.ready ##1 st.buf_cnt != 2'h3)
      else $error("buffer overrun");
   dummy_exit_a: assert property (
      cs_active && st.state == ST_DUMMY && rise_edge && st.dcnt == 4'h1
      |=> st.state == ST_ARRAY ##1 !MISO_OE_OUT || st.state == ST_ARRAY)
      else $error("dummy phase end wrong");

endmodule : frc_top

// ### pkg/frc_params.svh
// offsets, field positions, reset values and command codes of the
// flash read-configuration block; included by the design and the bench
`ifndef FRC_PARAMS_SVH
`define FRC_PARAMS_SVH
`define FRC_NV_RESET      16'hffff
`define FRC_VOL_RESET     8'hfb
`define FRC_DUMMY_DEFAULT 4'ha
`define FRC_DUMMY_HI      7
`define FRC_DUMMY_LO      4
`define FRC_XIP_BIT       3
`define FRC_RSVD_BIT      2
`define FRC_NV_QUAD_BIT   3
`define FRC_NV_DUAL_BIT   2
`define FRC_WRAP_16       2'h0
`define FRC_WRAP_32       2'h1
`define FRC_WRAP_64       2'h2
`define FRC_OP_RD_NV      8'hb5
`define FRC_OP_WR_NV      8'hb1
`define FRC_OP_RD_VOL     8'h85
`define FRC_OP_WR_VOL     8'h81
`define FRC_OP_FAST_READ  8'h0b
`endif

// ### pkg/frc_pkg.sv
// types of the flash read-configuration block
// assumes frc_params.svh is on the include path
package frc_pkg;
   typedef enum logic [2:0] {
      ST_CMD    = 3'b000,
      ST_WDATA  = 3'b001,
      ST_ADDR   = 3'b010,
      ST_DUMMY  = 3'b011,
      ST_ARRAY  = 3'b100,
      ST_REG    = 3'b101,
      ST_IGNORE = 3'b110
   } frc_state_t;

   typedef struct packed {
      frc_state_t      state;
      logic [2:0]      sclk_sync;
      logic [1:0]      cs_sync;
      logic [1:0]      mosi_sync;
      logic [4:0]      bit_cnt;
      logic [23:0]     in_sr;
      logic            is_nv;
      logic [15:0]     out_sr;
      logic [2:0]      out_bit;
      logic [3:0]      dcnt;
      logic [23:0]     fill_addr;
      logic            fill_on;
      logic [1:0][7:0] buf_mem;
      logic            wr_ptr;
      logic            rd_ptr;
      logic [1:0]      buf_cnt;
      logic            ready;
      logic            miso;
      logic            miso_oe;
      logic [15:0]     nv;
      logic [7:0]      vol;
      logic            quad;
      logic            dual;
      logic            execute_in_place_mode;
   } frc_regs_t;
endpackage : frc_pkg

// ### verif/frc_host_model.sv
// spi host model for the flash read-configuration block: frames, bytes,
// dummy edges. assumes a caller that enters its tasks at a clk_in edge.
`timescale 1ns/1ps

module frc_host_model (
   input  wire logic       clk_in,
   input  wire logic       miso_in,
   output logic            sclk_out,
   output logic            cs_n_out,
   output logic            mosi_out,
   output logic [7:0]      rx_byte_out,
   output logic            rx_stb_out
);
   initial begin
      sclk_out    = 1'b0;
      cs_n_out    = 1'b1;
      mosi_out    = 1'b0;
      rx_byte_out = 8'h00;
      rx_stb_out  = 1'b0;
   end

   // 64 ns sclk; miso taken late in the high phase, well clear of changes
   task automatic bit_xfer(input logic b, output logic r);
      sclk_out <= 1'b0;
      mosi_out <= b;
      repeat (4) @(posedge clk_in);
      sclk_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      r = miso_in;
   endtask : bit_xfer

   task automatic begin_frame;
      cs_n_out <= 1'b0;
      sclk_out <= 1'b0;
      repeat (4) @(posedge clk_in);
   endtask : begin_frame

   // sclk stands low outside frames; gap well over 3 clocks
   task automatic end_frame;
      sclk_out <= 1'b0;
      repeat (4) @(posedge clk_in);
      cs_n_out <= 1'b1;
      repeat (8) @(posedge clk_in);
   endtask : end_frame

   task automatic send_byte(input logic [7:0] v);
      logic r;
      for (int i = 7; i >= 0; i--) bit_xfer(v[i], r);
   endtask : send_byte

   // host inserts exactly the dummy edges it configured
   task automatic dummy(input int n);
      logic r;
      for (int i = 0; i < n; i++) bit_xfer(~mosi_out, r);
   endtask : dummy

   // mosi toggles while only miso matters, so no stale value lingers
   task automatic get_byte;
      logic [7:0] v;
      for (int i = 7; i >= 0; i--) bit_xfer(~mosi_out, v[i]);
      rx_byte_out <= v;
      rx_stb_out  <= 1'b1;
      @(posedge clk_in);
      rx_stb_out  <= 1'b0;
   endtask : get_byte
endmodule : frc_host_model

// ### verif/frc_top_bench.sv
// self-checking bench for frc_top: register commands, fast read with
// dummy counts and wrap. assumes frc_params.svh on the include path.
`timescale 1ns/1ps
`include "frc_params.svh"

module frc_top_bench;
   logic        clk;
   logic        arst_n;
   logic        valid;
   wire         sclk, cs_n, mosi, ready, miso, oe, quad, dual, execute_in_place_mode, rxs;
   wire  [23:0] addr;
   wire  [7:0]  vol, rxb;
   wire  [7:0]  adata = addr[7:0] ^ 8'h3c;
   logic [7:0]  exp_q[$];
   logic [29:0] tab [5] = '{{4'h0, 2'h0, 24'h12340e},
      {4'hf, 2'h1, 24'habcd1e}, {4'h1, 2'h2, 24'h00003e},
      {4'h3, 2'h3, 24'h0000fe}, {4'he, 2'h0, 24'h55555f}};
   int          n_errors, total_checks, cycles;
   logic [31:0] d;

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   frc_top #(.XIP_FORCED(1'b0)) dut (
      .CLOCK_IN(clk), .ARST_N_IN(arst_n), .SCLK_IN(sclk), .CS_N_IN(cs_n),
      .MOSI_IN(mosi), .ARRAY_DATA_IN(adata), .ARRAY_VALID_IN(valid),
      .ARRAY_READY_OUT(ready), .ARRAY_ADDR_OUT(addr), .MISO_OUT(miso),
      .MISO_OE_OUT(oe), .QUAD_MODE_OUT(quad), .DUAL_MODE_OUT(dual),
      .EXECUTE_IN_PLACE_MODE_OUT(execute_in_place_mode), .VOL_CONFIG_OUT(vol));

   frc_host_model host (
      .clk_in(clk), .miso_in(oe ? miso : ~miso), .sclk_out(sclk),
      .cs_n_out(cs_n),
      .mosi_out(mosi), .rx_byte_out(rxb), .rx_stb_out(rxs));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic conclude;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : conclude

   // oldest note against each byte the host model hands back
   always @(posedge clk) begin
      if (rxs === 1'b1) begin
         if (exp_q.size() == 0) chk({8'h00, rxb}, 16'hffff);
         else chk({8'h00, rxb}, {8'h00, exp_q.pop_front()});
         chk({15'h0, oe}, 16'h0001);
      end
   end

   // array source stalls at random; ready low must hold bytes back
   always @(posedge clk) valid <= ($urandom % 4) != 0;

   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         n_errors++;
         conclude();
      end
   end

   task automatic wr_vol(input logic [7:0] v);
      host.begin_frame();
      host.send_byte(`FRC_OP_WR_VOL);
      host.send_byte(v);
      host.end_frame();
      chk({8'h00, vol}, {8'h00, v & 8'hfb});
      chk({15'h0, execute_in_place_mode}, {15'h0, ~v[3]});
      chk({15'h0, oe}, 16'h0000);
   endtask : wr_vol

   task automatic rd_vol(input logic [7:0] e);
      host.begin_frame();
      host.send_byte(`FRC_OP_RD_VOL);
      exp_q.push_back(e);
      host.get_byte();
      host.end_frame();
   endtask : rd_vol

   task automatic rd_nv(input logic [15:0] e);
      host.begin_frame();
      host.send_byte(`FRC_OP_RD_NV);
      exp_q.push_back(e[15:8]);
      exp_q.push_back(e[7:0]);
      host.get_byte();
      host.get_byte();
      host.end_frame();
   endtask : rd_nv

   task automatic wr_nv(input logic [15:0] v);
      host.begin_frame();
      host.send_byte(`FRC_OP_WR_NV);
      host.send_byte(v[15:8]);
      host.send_byte(v[7:0]);
      host.end_frame();
   endtask : wr_nv

   task automatic fast_read(input logic [29:0] t);
      logic [23:0] a, m;
      int          n;
      a = t[23:0];
      n = (t[29:26] == 4'h0 || t[29:26] == 4'hf) ? 10 : int'(t[29:26]);
      m = (t[25:24] == 2'h0) ? 24'hf : (t[25:24] == 2'h1) ? 24'h1f :
          (t[25:24] == 2'h2) ? 24'h3f : 24'hffffff;
      wr_vol({t[29:26], 2'b10, t[25:24]});
      host.begin_frame();
      host.send_byte(`FRC_OP_FAST_READ);
      host.send_byte(a[23:16]);
      host.send_byte(a[15:8]);
      host.send_byte(a[7:0]);
      host.dummy(n);
      for (int k = 0; k < 5; k++) begin
         exp_q.push_back(a[7:0] ^ 8'h3c);
         a = (a & ~m) | ((a + 24'h1) & m);
      end
      for (int k = 0; k < 5; k++) host.get_byte();
      host.end_frame();
   endtask : fast_read

   initial begin
      arst_n       = 1'b0;
      valid        = 1'b0;
      cycles       = 0;
      n_errors     = 0;
      total_checks = 0;
      d            = $urandom(38);
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk({8'h00, vol}, 16'h00fb);
      chk({14'h0, quad, dual}, 16'h0000);
      chk({15'h0, execute_in_place_mode}, 16'h0000);
      rd_vol(8'hfb);
      rd_nv(16'hffff);
      d = $urandom;
      wr_nv(d[15:0] & 16'hfff3);
      rd_nv(d[15:0] & 16'hfff3);
      chk({14'h0, quad, dual}, 16'h0000);
      for (int i = 0; i < 2; i++) begin
         d    = $urandom;
         d[3] = i[0];
         wr_vol(d[7:0]);
         rd_vol(d[7:0] & 8'hfb);
      end
      host.begin_frame();
      host.send_byte(`FRC_OP_WR_VOL);
      host.dummy(4);
      host.end_frame();
      chk({8'h00, vol}, {8'h00, d[7:0] & 8'hfb});
      host.begin_frame();
      host.send_byte(8'h9f);
      host.send_byte(`FRC_OP_RD_VOL);
      chk({15'h0, oe}, 16'h0000);
      host.end_frame();
      for (int i = 0; i < 5; i++) fast_read(tab[i]);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk({8'h00, vol}, 16'h00fb);
      rd_nv(16'hffff);
      chk(16'(exp_q.size()), 16'h0000);
      conclude();
   end
endmodule : frc_top_bench
